//--- rtl/pei_pkg.sv
// Constants and types for the power event interrupt logic
package pei_pkg;
   localparam int NUM_CH = 4;
   localparam int NUM_PAIR = 2;
   // Command codes
   localparam logic [7:0] CMD_INT_MASK = 8'h01;
   localparam logic [7:0] CMD_PWR_EVT = 8'h02;
   localparam logic [7:0] CMD_PWR_EVT_COR = 8'h03;
   // Mask and status bit positions
   localparam int BIT_SUPPLY = 7;
   localparam int BIT_START = 6;
   localparam int BIT_OVERLOAD = 5;
   localparam int BIT_CLASS = 4;
   localparam int BIT_DETECT = 3;
   localparam int BIT_DISCONNECT = 2;
   localparam int BIT_PG_CHG = 1;
   localparam int BIT_PE_CHG = 0;
   // Reset values
   localparam logic [7:0] MASK_RESET = 8'h80;
   localparam logic [7:0] PWR_EVT_RESET = 8'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // Power event register layout, good changes in the upper nibble
   typedef struct packed {
      logic [NUM_CH-1:0] pwr_good_change_flags;
      logic [NUM_CH-1:0] pwr_en_change_flags;
   } pei_pwr_evt_t;

   // One register command from the host link
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
      logic [7:0] wdata;
   } pei_cmd_t;

   // Per-channel status levels
   typedef struct packed {
      logic [NUM_CH-1:0] pwr_good;
      logic [NUM_CH-1:0] pwr_en;
   } pei_chan_stat_t;
endpackage

//--- rtl/pei_power_event_irq.sv
// Power event flags, interrupt mask and active-low interrupt generation
`timescale 1ns/100ps
`default_nettype none
module pei_power_event_irq (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Register command port
   input wire pei_pkg::pei_cmd_t cmd_i,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o,
   // Channel status levels and port wiring
   input wire pei_pkg::pei_chan_stat_t chan_stat_i,
   input wire logic [pei_pkg::NUM_PAIR-1:0] four_pair_i,
   input wire logic [pei_pkg::NUM_PAIR-1:0] single_sig_i,
   // Other summary bits and global controls
   input wire logic [7:2] other_status_i,
   input wire logic global_irq_enable_i,
   input wire logic clear_all_i,
   // Status and interrupt
   output logic [7:0] irq_status_o,
   output logic [7:0] irq_mask_o,
   output logic irq_n_o
);
   import pei_pkg::*;

   // Command decode, shared by read and write paths
   function automatic logic cmd_hit(input pei_cmd_t c, input logic [7:0] code, input logic wr);
      cmd_hit = c.valid && (c.code == code) && (c.write == wr);
   endfunction

   // Reset copy
   logic [1:0] rst_sync_q;
   logic rst_n;
   // Register state
   logic [7:0] mask_q;
   pei_pwr_evt_t evt_q;
   pei_pwr_evt_t evt_set;
   // Change detection and single-signature pairing
   pei_chan_stat_t stat_q;
   logic [NUM_CH-1:0] pg_chg;
   logic [NUM_CH-1:0] pe_chg;
   logic [NUM_CH-1:0] pg_set;
   logic [NUM_CH-1:0] pg_pend_q;
   logic [NUM_CH-1:0] pg_pend_d;
   // Summary, clear and outputs
   logic [7:0] status;
   logic evt_clear;
   logic irq_n_q;
   logic rd_valid_q;
   logic [7:0] rd_data_q;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Previous status levels for change detection
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= '0;
      end else begin
         stat_q <= chan_stat_i;
      end
   end
   assign pg_chg = chan_stat_i.pwr_good ^ stat_q.pwr_good;
   assign pe_chg = chan_stat_i.pwr_en ^ stat_q.pwr_en;

   // Per pair flag setting; channel 2p+1 and 2p share one four-pair port
   for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
      logic joint;
      logic [1:0] pend_now;
      logic [1:0] good_set;
      logic [1:0] pend_next;
      assign joint = four_pair_i[p] && single_sig_i[p];
      assign pend_now = pg_pend_q[2*p+:2] | pg_chg[2*p+:2];
      // Hold the first channel's change so the host sees one interrupt
      always_comb begin
         if (joint) begin
            good_set = (&pend_now) ? 2'h3 : 2'h0;
            pend_next = (&pend_now) ? 2'h0 : pend_now;
         end else begin
            // Dropping the pending half here is why a wiring change forgets it
            good_set = pg_chg[2*p+:2];
            pend_next = 2'h0;
         end
      end
      // Each pair owns its own slice, so the drivers never overlap
      assign pg_set[2*p+:2] = good_set;
      assign pg_pend_d[2*p+:2] = pend_next;
   end

   // Enable changes always land per channel, any wiring
   assign evt_set = '{pwr_good_change_flags: pg_set, pwr_en_change_flags: pe_chg};

   // Pending good-change history for single-signature ports
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pg_pend_q <= '0;
      end else begin
         pg_pend_q <= pg_pend_d;
      end
   end

   // Clear-on-read or global clear empties the flags
   assign evt_clear = cmd_hit(cmd_i, CMD_PWR_EVT_COR, 1'b0) || clear_all_i;

   // Event flags; a set in the clearing cycle survives the clear
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         evt_q <= PWR_EVT_RESET;
      end else begin
         evt_q <= (evt_clear ? PWR_EVT_RESET : evt_q) | evt_set;
      end
   end

   // Mask register, written by command 01h
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= MASK_RESET;
      end else if (cmd_hit(cmd_i, CMD_INT_MASK, 1'b1)) begin
         mask_q <= cmd_i.wdata;
      end
   end

   // Summary bits ignore the mask entirely
   always_comb begin
      status = {other_status_i, 2'h0};
      status[BIT_PE_CHG] = |evt_q.pwr_en_change_flags;
      status[BIT_PG_CHG] = |evt_q.pwr_good_change_flags;
   end

   // Registered interrupt keeps the pin glitch free at one cycle of latency
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= !(global_irq_enable_i && |(status & mask_q));
      end
   end

   // Read path; 02h and 03h return identical data
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= RDATA_RESET;
      end else begin
         rd_valid_q <= cmd_i.valid && !cmd_i.write;
         if (cmd_hit(cmd_i, CMD_INT_MASK, 1'b0)) begin
            rd_data_q <= mask_q;
         end else if (cmd_hit(cmd_i, CMD_PWR_EVT, 1'b0) ||
                      cmd_hit(cmd_i, CMD_PWR_EVT_COR, 1'b0)) begin
            rd_data_q <= evt_q;
         end else if (cmd_i.valid && !cmd_i.write) begin
            rd_data_q <= RDATA_RESET; // Unknown codes read as zero
         end
      end
   end

   assign rd_valid_o = rd_valid_q;
   assign rd_data_o = rd_data_q;
   assign irq_status_o = status;
   assign irq_mask_o = mask_q;
   assign irq_n_o = irq_n_q;

   // Checks; all on the one clock, quiet while the reset copy is low.
   // The pin is registered, so most pin checks look one edge after
   // the status, mask and enable that drive it.
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_cor_read;
      cmd_hit(cmd_i, CMD_PWR_EVT_COR, 1'b0) && (evt_set == '0);
   endsequence
   sequence s_flags_gone;
      ##1 (evt_q == '0);
   endsequence

   mask_write_a: assert property (
      cmd_hit(cmd_i, CMD_INT_MASK, 1'b1) |=> (mask_q == $past(cmd_i.wdata)))
      else $error("mask write not stored");
   irq_masked_a: assert property (
      ((status & mask_q) == 8'h00) |=> irq_n_o)
      else $error("interrupt active with every source masked");
   irq_enable_a: assert property (
      !global_irq_enable_i |=> irq_n_o)
      else $error("interrupt active without global enable");
   irq_assert_a: assert property (
      (global_irq_enable_i && |(status & mask_q)) |=> !irq_n_o)
      else $error("interrupt not asserted for unmasked status");
   cor_clear_a: assert property (
      s_cor_read |-> s_flags_gone)
      else $error("clear-on-read left flags set");
   read_same_a: assert property (
      (cmd_hit(cmd_i, CMD_PWR_EVT, 1'b0) || cmd_hit(cmd_i, CMD_PWR_EVT_COR, 1'b0))
      |=> (rd_valid_o && rd_data_o == $past(evt_q)))
      else $error("event read returned wrong data");
   pe_summary_a: assert property (
      status[BIT_PE_CHG] == |evt_q.pwr_en_change_flags)
      else $error("enable change summary wrong");
   pg_summary_a: assert property (
      status[BIT_PG_CHG] == |evt_q.pwr_good_change_flags)
      else $error("good change summary wrong");
   pe_flag_set_a: assert property (
      pe_chg[0] |=> evt_q.pwr_en_change_flags[0])
      else $error("enable change not flagged");
   pg_joint_a: assert property (
      (four_pair_i[0] && single_sig_i[0] && $changed(chan_stat_i.pwr_good[0])
       && !pg_pend_q[1] && !pg_chg[1] && !clear_all_i
       && !cmd_hit(cmd_i, CMD_PWR_EVT_COR, 1'b0))
      |=> (evt_q.pwr_good_change_flags[1:0] == $past(evt_q.pwr_good_change_flags[1:0])))
      else $error("single-signature good change flagged early");
   cor_release_a: assert property (
      (s_cor_read ##1 (evt_set == '0) ##1 (mask_q[BIT_SUPPLY:BIT_DISCONNECT] == 6'h00))
      |=> irq_n_o)
      else $error("clear-on-read did not release interrupt");

   // Read port: one answer pulse per read, data held in between
   sequence s_any_read;
      cmd_i.valid && !cmd_i.write;
   endsequence
   sequence s_unknown_code;
      (cmd_i.code != CMD_INT_MASK) && (cmd_i.code != CMD_PWR_EVT)
      && (cmd_i.code != CMD_PWR_EVT_COR);
   endsequence

   // Every read is answered exactly one edge later
   rd_answer_a: assert property (
      s_any_read |=> rd_valid_o)
      else $error("read command not answered");
   // No pulse without a read, or the host would take a stray byte
   rd_quiet_a: assert property (
      !(cmd_i.valid && !cmd_i.write) |=> !rd_valid_o)
      else $error("answer pulse without a read");
   // Read data holds between reads
   rd_hold_a: assert property (
      !(cmd_i.valid && !cmd_i.write) |=> $stable(rd_data_o))
      else $error("read data moved without a read");
   // Mask read returns the mask as it stood when the read was taken
   mask_read_a: assert property (
      cmd_hit(cmd_i, CMD_INT_MASK, 1'b0) |=> (rd_data_o == $past(mask_q)))
      else $error("mask read returned wrong data");
   // Unknown codes answer zero so a stray read never shows stale data
   unknown_read_a: assert property (
      (s_any_read ##0 s_unknown_code) |=> (rd_data_o == RDATA_RESET))
      else $error("unknown code read returned data");

   // Mask and flags only move through their own paths
   mask_hold_a: assert property (
      !cmd_hit(cmd_i, CMD_INT_MASK, 1'b1) |=> $stable(mask_q))
      else $error("mask changed without a write");
   // Flags are sticky: nothing but a clear may drop one
   flags_sticky_a: assert property (
      !evt_clear |=> ((evt_q & $past(evt_q)) == $past(evt_q)))
      else $error("event flag dropped without a clear");
   // A flag rises only where a change was flagged the cycle before
   flag_cause_a: assert property (
      (evt_set == '0) |=> ((evt_q & ~$past(evt_q)) == '0))
      else $error("event flag set without a change");
   // The global clear empties the whole register
   clear_all_a: assert property (
      (clear_all_i && (evt_set == '0)) |=> (evt_q == '0))
      else $error("global clear left flags set");

   // Enable changes land on their own channel bits, whatever the wiring
   pe_flags_a: assert property (
      (pe_chg != '0)
      |=> ((evt_q.pwr_en_change_flags & $past(pe_chg)) == $past(pe_chg)))
      else $error("enable change flags incomplete");
   for (genvar c = 0; c < NUM_CH; c++) begin : g_chan_chk
      // Each channel's change shows in its own bit
      chan_own_a: assert property (
         pe_chg[c] |=> evt_q.pwr_en_change_flags[c])
         else $error("channel change missing from its own flag");
   end

   // Dual-signature and two-pair ports flag good changes per channel
   pg_dual_a: assert property (
      (!(four_pair_i[0] && single_sig_i[0]) && (pg_chg[1:0] != 2'h0))
      |=> ((evt_q.pwr_good_change_flags[1:0] & $past(pg_chg[1:0])) == $past(pg_chg[1:0])))
      else $error("dual-signature good change not flagged");
   // Same for the second pair
   pg_dual_hi_a: assert property (
      (!(four_pair_i[1] && single_sig_i[1]) && (pg_chg[3:2] != 2'h0))
      |=> ((evt_q.pwr_good_change_flags[3:2] & $past(pg_chg[3:2])) == $past(pg_chg[3:2])))
      else $error("dual-signature good change not flagged");

   // Single-signature port: both halves seen means both flags at once
   sequence s_joint_both;
      four_pair_i[1] && single_sig_i[1] && (&(pg_pend_q[3:2] | pg_chg[3:2]));
   endsequence
   sequence s_joint_both_lo;
      four_pair_i[0] && single_sig_i[0] && (&(pg_pend_q[1:0] | pg_chg[1:0]));
   endsequence
   pg_joint_both_a: assert property (
      s_joint_both |=> (evt_q.pwr_good_change_flags[3:2] == 2'h3))
      else $error("single-signature pair not flagged together");
   pg_joint_lo_a: assert property (
      s_joint_both_lo |=> (evt_q.pwr_good_change_flags[1:0] == 2'h3))
      else $error("single-signature pair not flagged together");
   // One half seen so far is remembered, not flagged
   pend_keep_a: assert property (
      (four_pair_i[0] && single_sig_i[0] && !(&(pg_pend_q[1:0] | pg_chg[1:0])))
      |=> (pg_pend_q[1:0] == ($past(pg_pend_q[1:0]) | $past(pg_chg[1:0]))))
      else $error("pending good change lost");
   // Leaving single-signature wiring forgets the pending half
   pend_drop_a: assert property (
      !(four_pair_i[0] && single_sig_i[0]) |=> (pg_pend_q[1:0] == 2'h0))
      else $error("pending good change kept on other wiring");
   pend_drop_hi_a: assert property (
      !(four_pair_i[1] && single_sig_i[1]) |=> (pg_pend_q[3:2] == 2'h0))
      else $error("pending good change kept on other wiring");

   // Summary bits 7 to 2 pass straight through, untouched by the mask
   other_status_a: assert property (
      status[BIT_SUPPLY:BIT_DISCONNECT] == other_status_i)
      else $error("outside summary bits altered");
   // Good-change source alone pulls the pin when its mask bit is set
   pg_pin_a: assert property (
      (status[BIT_PG_CHG] && mask_q[BIT_PG_CHG] && global_irq_enable_i) |=> !irq_n_o)
      else $error("good change summary did not pull the pin");
   // Supply summary alone pulls the pin when its mask bit is set
   supply_pin_a: assert property (
      (status[BIT_SUPPLY] && mask_q[BIT_SUPPLY] && global_irq_enable_i) |=> !irq_n_o)
      else $error("supply summary did not pull the pin");

   // Whole walk of one event: level change, flag, then the pin
   sequence s_pe_walk;
      pe_chg[0] ##1 (mask_q[BIT_PE_CHG] && global_irq_enable_i);
   endsequence
   evt_to_pin_a: assert property (
      s_pe_walk |=> !irq_n_o)
      else $error("enable change did not reach the pin");
endmodule
`default_nettype wire

//--- tb/pei_host_model.sv
// Host model issuing one-byte register commands
`timescale 1ns/100ps
`default_nettype none
module pei_host_model (
   // Clock and read answer
   input wire logic clk_i,
   input wire logic rd_valid_i,
   input wire logic [7:0] rd_data_i,
   // Command request
   output var pei_pkg::pei_cmd_t cmd_o
);
   import pei_pkg::*;
   initial cmd_o = '0;
   // One pulse per command; reads wait a bounded time for the answer
   task automatic xfer(input logic w, input logic [7:0] code, input logic [7:0] wd,
                       output logic [7:0] rd, output bit ok);
      int n;
      @(negedge clk_i);
      cmd_o = '{valid: 1'b1, write: w, code: code, wdata: wd};
      @(negedge clk_i);
      cmd_o.valid = 1'b0;
      ok = w;
      rd = 8'h00;
      for (n = 0; n < 3 && !ok; n++) begin
         if (rd_valid_i === 1'b1) begin
            rd = rd_data_i;
            ok = 1'b1;
         end else begin
            @(negedge clk_i);
         end
      end
   endtask
endmodule
`default_nettype wire

//--- tb/pei_power_event_irq_tb.sv
// Self-checking bench for the power event interrupt logic
`timescale 1ns/100ps
`default_nettype none
module pei_power_event_irq_tb;
   import pei_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, clr = 1'b0, rv, irqn;
   logic [7:0] rd, st, mk, rdv, ex;
   logic [7:0] flags = 8'h00, mask = 8'h80;
   logic [7:2] oth = '0;
   logic [1:0] fp = '0, ss = '0;
   logic [3:0] pend = '0;
   pei_cmd_t cmd;
   pei_chan_stat_t cs = '0;
   int error_cnt = 0, check_count = 0, i, b;
   bit ok;
   initial forever #4 clk = ~clk;
   pei_power_event_irq dut (.ref_clk_i(clk), .reset_n_i(rst_n), .cmd_i(cmd),
      .rd_valid_o(rv), .rd_data_o(rd), .chan_stat_i(cs), .four_pair_i(fp),
      .single_sig_i(ss), .other_status_i(oth), .global_irq_enable_i(en),
      .clear_all_i(clr), .irq_status_o(st), .irq_mask_o(mk), .irq_n_o(irqn));
   pei_host_model host (.clk_i(clk), .rd_valid_i(rv), .rd_data_i(rd), .cmd_o(cmd));
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Read through the host; a missing answer ends the run
   task automatic reg_rd(input logic [7:0] code, input logic [7:0] exp);
      host.xfer(1'b0, code, 8'h00, rdv, ok);
      if (!ok) begin
         error_cnt++;
         print_verdict();
      end else begin
         chk(rdv, exp);
      end
   endtask
   // Toggle one status bit; bit b of the status maps onto flag bit b
   task automatic evt(input int bit_i);
      int c;
      c = bit_i % 4;
      cs[bit_i] = ~cs[bit_i];
      if (bit_i < 4 || !(fp[c/2] && ss[c/2])) begin
         flags[bit_i] = 1'b1;
      end else begin
         pend[c] = 1'b1;
         // Both halves of a single-signature port must change first
         if (pend[c & 2] && pend[(c & 2) + 1]) begin
            flags[4 + (c & 2)] = 1'b1;
            flags[5 + (c & 2)] = 1'b1;
            pend[c & 2] = 1'b0;
            pend[(c & 2) + 1] = 1'b0;
         end
      end
   endtask
   initial begin
      void'($urandom(9268));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      reg_rd(CMD_INT_MASK, MASK_RESET);
      reg_rd(CMD_PWR_EVT, PWR_EVT_RESET);
      chk({7'h00, irqn}, 8'h01);
      $display("test reset done");
      // Only the enable-change source may pull the pin; its read must free it
      mask = 8'h01;
      en = 1'b1;
      host.xfer(1'b1, CMD_INT_MASK, mask, rdv, ok);
      evt(0);
      repeat (3) @(negedge clk);
      chk({7'h00, irqn}, 8'h00);
      reg_rd(CMD_PWR_EVT_COR, flags);
      flags = 8'h00;
      repeat (3) @(negedge clk);
      chk({7'h00, irqn}, 8'h01);
      $display("test release done");
      for (i = 0; i < 500; i++) begin
         @(negedge clk);
         b = $urandom % 16;
         // A pair that is no longer single-signature four-pair drops its pending halves
         if (i % 100 == 0) begin
            fp = 2'($urandom);
            ss = 2'($urandom);
            for (int p = 0; p < NUM_PAIR; p++) begin
               if (!(fp[p] && ss[p])) pend[2*p+:2] = 2'h0;
            end
         end
         case (b)
            8: begin
               mask = 8'($urandom);
               host.xfer(1'b1, CMD_INT_MASK, mask, rdv, ok);
            end
            9: reg_rd(CMD_INT_MASK, mask);
            10: reg_rd(CMD_PWR_EVT, flags);
            11: begin
               reg_rd(CMD_PWR_EVT_COR, flags);
               flags = 8'h00;
            end
            12: begin
               clr = 1'b1;
               @(negedge clk);
               clr = 1'b0;
               flags = 8'h00;
            end
            13: begin
               en = 1'($urandom);
               oth = 6'($urandom);
            end
            14: host.xfer(1'b1, CMD_PWR_EVT, 8'($urandom), rdv, ok);
            15: reg_rd(8'h04 + 8'($urandom % 12), 8'h00);
            default: evt(b);
         endcase
         repeat (3) @(negedge clk);
         ex = {oth, |flags[7:4], |flags[3:0]};
         chk(st, ex);
         chk({7'h00, irqn}, {7'h00, !(en && |(ex & mask))});
         chk(mk, mask);
      end
      $display("test random done");
      print_verdict();
   end
endmodule
`default_nettype wire
